// *** hdl/sfd_dev.sv ***
// flash end of the dtr read path: single, dual and quad dtr reads
// assumes a host on the link pins and a combinational byte memory on mem_addr
// Functional notes
// - single read moves one bit per edge
// - single order: opcode, 24-bit address, dummy, data
// - address increments per byte, wraps to zero
// - chip select high ends read, drive stops
// - busy internal cycle makes reads ignored; enhance-mode reads skip the write_in_progress check and run
// - dual read moves two bits per edge
// - dual order: opcode, address, dummy, data on two
// - host sets quad enable before quad read
// - quad read moves four bits per edge
// - quad opcode serial eight or four-line two
// - toggling indicator nibbles enter enhance mode
// - host drives lines during indicator cycles
// - dummy count from two configuration bits
// - four-byte mode lengthens address phase
// - preamble enable drives pattern in dummy
// - preamble starts after indicator cycles only
// - preamble is 00110100, first bit first
// - ten dummy clocks give all eight bits
// - fewer dummy clocks truncate trailing preamble bits
// - indicator value keeps or leaves enhance mode
// - enhance mode skips opcode after reselect
`timescale 1ns/1ps
module sfd_dev #(
  parameter int MEM_AW = 26
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  sfd_link_if.dev link,
  output logic [MEM_AW-1:0] mem_addr,
  input wire logic [7:0] mem_data,
  input wire logic write_in_progress,
  input wire logic dummy_count_bit1,
  input wire logic dummy_count_bit0,
  input wire logic preamble_enable_bit,
  input wire logic four_line_command_mode,
  input wire logic addr_4byte,
  output logic enhance_active
);
  import sfd_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_SKIP} sfd_dst_e;

  ////////////////////////////////////////////////////////////////////////////
  // pin capture

  logic [2:0] sck_q;
  logic [1:0] cs_q;
  logic [3:0] io_q1, io_q2;

  // second stage feeds logic; third sclk stage exists only for edge finding
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_q <= 3'h0;
      cs_q <= 2'h3;
      io_q1 <= 4'hF;
      io_q2 <= 4'hF;
    end
    else
    begin
      sck_q <= {sck_q[1:0], link.sclk};
      cs_q <= {cs_q[0], link.cs_n};
      io_q1 <= link.io;
      io_q2 <= io_q1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer

  sfd_dst_e st_r, st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  sfd_wsh_t wsh_r, wsh_nxt;
  logic [7:0] opc_r, opc_nxt, sh_r, sh_nxt, unit_b, op_v;
  logic [31:0] adr_r, adr_nxt, adr_v;
  logic [3:0] ind_r, ind_nxt, io_o_r, io_o_nxt, io_oe_r, io_oe_nxt, dclk;
  logic [2:0] ucnt_r, ucnt_nxt, u_last, pidx;
  logic [MEM_AW-1:0] maddr_r, maddr_nxt;
  logic enh_r, enh_nxt, rise, fall, pre_on;
  logic [5:0] a_last, d_last;
  logic [4:0] c_next;

  assign rise = sck_q[1] & ~sck_q[2];
  assign fall = ~sck_q[1] & sck_q[2];
  assign dclk = sfd_dummy_clks(dummy_count_bit1, dummy_count_bit0);
  assign a_last = ((addr_4byte ? ADDR4_BITS : ADDR3_BITS) >> wsh_r) - 6'h01;
  assign d_last = {1'b0, dclk, 1'b0} - 6'h01;
  assign c_next = cnt_r[5:1] + 5'h01;
  assign pidx = 3'(c_next - IND_CLKS);
  // preamble occupies dummy clocks after the indicator slot, cut at the end
  assign pre_on = preamble_enable_bit && c_next >= IND_CLKS && c_next < {1'b0, dclk};
  assign u_last = 3'h7 >> wsh_r;
  assign unit_b = (ucnt_r == 3'h0) ? mem_data : sh_r;
  assign op_v = four_line_command_mode ? {opc_r[3:0], io_q2} : {opc_r[6:0], io_q2[0]};
  assign adr_v = sfd_shin(wsh_r, adr_r, io_q2, 1'b0);
  assign mem_addr = maddr_r;
  assign enhance_active = enh_r;
  assign link.dev_io_o = io_o_r;
  assign link.dev_io_oe = io_oe_r;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wsh_nxt = wsh_r;
    opc_nxt = opc_r;
    adr_nxt = adr_r;
    ind_nxt = ind_r;
    sh_nxt = sh_r;
    ucnt_nxt = ucnt_r;
    maddr_nxt = maddr_r;
    enh_nxt = enh_r;
    io_o_nxt = io_o_r;
    io_oe_nxt = io_oe_r;
    if (cs_q[1])
    begin
      // deselect aborts anything and releases the lines at once
      st_nxt = ST_IDLE;
      io_oe_nxt = 4'h0;
      cnt_nxt = 6'h00;
    end
    else
    begin
      unique case (st_r)
        ST_IDLE:
        begin
          cnt_nxt = 6'h00;
          ucnt_nxt = 3'h0;
          opc_nxt = 8'h00;
          adr_nxt = 32'h0;
          if (enh_r)
          begin
            st_nxt = ST_ADDR;
            wsh_nxt = W_QUAD;
          end
          else
            st_nxt = ST_OPC;
        end
        ST_OPC:
        begin
          if (rise)
          begin
            opc_nxt = op_v;
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r[2:0] == (four_line_command_mode ? OPC_RISES_QPI : OPC_RISES_SPI))
            begin
              cnt_nxt = 6'h00;
              st_nxt = ST_ADDR;
              if (op_v == OPC_QUAD)
                wsh_nxt = W_QUAD;
              else if (op_v == OPC_DUAL && !four_line_command_mode)
                wsh_nxt = W_DUAL;
              else if (op_v == OPC_SINGLE && !four_line_command_mode)
                wsh_nxt = W_SINGLE;
              else
                st_nxt = ST_SKIP;
              // a running program or erase is never disturbed by a read that starts with an opcode
              if (write_in_progress)
                st_nxt = ST_SKIP;
            end
          end
        end
        ST_ADDR:
        begin
          // the address always opens on a rising edge, then takes both edges
          if (rise || (fall && cnt_r != 6'h00))
          begin
            adr_nxt = adr_v;
            cnt_nxt = cnt_r + 6'h01;
            if (cnt_r == a_last)
            begin
              st_nxt = ST_DUMMY;
              cnt_nxt = 6'h00;
              maddr_nxt = adr_v[MEM_AW-1:0];
            end
          end
        end
        ST_DUMMY:
        begin
          if (rise || fall)
          begin
            cnt_nxt = cnt_r + 6'h01;
            if (wsh_r == W_QUAD && cnt_r == 6'h00)
              ind_nxt = io_q2;
            // any non-toggling pattern drops the mode on the second indicator edge, before the next reselect
            if (wsh_r == W_QUAD && cnt_r == 6'h01)
              enh_nxt = (ind_r ^ io_q2) == IND_TOGGLE;
          end
          if (fall && cnt_r == d_last)
          begin
            st_nxt = ST_DATA;
            io_o_nxt = sfd_lines(wsh_r, unit_b, 1'b0);
            io_oe_nxt = sfd_lines(wsh_r, 8'hFF, 1'b0);
            sh_nxt = 8'(sfd_shl(wsh_r, {24'h0, unit_b}));
            ucnt_nxt = (u_last == 3'h0) ? 3'h0 : 3'h1;
            maddr_nxt = maddr_r + 1'b1;
          end
          else if (fall && pre_on)
          begin
            io_o_nxt = sfd_lines(wsh_r, {8{PREAMBLE[3'h7 - pidx]}}, 1'b0);
            io_oe_nxt = sfd_lines(wsh_r, 8'hFF, 1'b0);
          end
        end
        ST_DATA:
        begin
          // one unit per edge; a fresh byte moves the pointer on
          if (rise || fall)
          begin
            io_o_nxt = sfd_lines(wsh_r, unit_b, 1'b0);
            sh_nxt = 8'(sfd_shl(wsh_r, {24'h0, unit_b}));
            ucnt_nxt = (ucnt_r == u_last) ? 3'h0 : ucnt_r + 3'h1;
            if (ucnt_r == 3'h0)
              maddr_nxt = maddr_r + 1'b1;
          end
        end
        ST_SKIP:
        begin
          io_oe_nxt = 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 6'h00;
      wsh_r <= W_SINGLE;
      opc_r <= 8'h00;
      adr_r <= 32'h0;
      ind_r <= 4'h0;
      sh_r <= 8'h00;
      ucnt_r <= 3'h0;
      maddr_r <= '0;
      enh_r <= 1'b0;
      io_o_r <= 4'h0;
      io_oe_r <= 4'h0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wsh_r <= wsh_nxt;
      opc_r <= opc_nxt;
      adr_r <= adr_nxt;
      ind_r <= ind_nxt;
      sh_r <= sh_nxt;
      ucnt_r <= ucnt_nxt;
      maddr_r <= maddr_nxt;
      enh_r <= enh_nxt;
      io_o_r <= io_o_nxt;
      io_oe_r <= io_oe_nxt;
    end
  end
endmodule : sfd_dev

// *** hdl/sfd_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth need not be a power of two
`timescale 1ns/1ps
module sfd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = cnt_r != FULL;
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and fill bookkeeping
  always_comb
  begin
    wp_nxt = push ? ((wp_r == LAST) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == LAST) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage has no reset; empty flag guards stale words
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end
endmodule : sfd_fifo

// *** hdl/sfd_host.sv ***
// host end: issues one dtr read per command and streams bytes out
// assumes the flash end on the link and a consumer on the rd_ stream
`timescale 1ns/1ps
module sfd_host #(
  parameter int HALF = sfd_pkg::HALF_DEFAULT,
  parameter int DEPTH = sfd_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  sfd_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sfd_pkg::sfd_wsh_t cmd_width,
  input wire logic [31:0] cmd_addr,
  input wire logic [15:0] cmd_len,
  input wire logic [7:0] cmd_ind,
  input wire logic cmd_cont,
  input wire logic quad_enable_bit,
  input wire logic four_line_command_mode,
  input wire logic addr_4byte,
  input wire logic dummy_count_bit1,
  input wire logic dummy_count_bit0,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic busy
);
  import sfd_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_RUN, H_END} sfd_hst_e;
  localparam logic [7:0] HC_DRV = 8'(HALF / 2);
  localparam logic [7:0] HC_SMP = 8'(HALF - 2);
  localparam logic [7:0] HC_TOG = 8'(HALF - 1);

  sfd_hst_e st_r, st_nxt;
  logic [7:0] hc_r, hc_nxt, op_r, op_nxt, ind_r, ind_nxt, rx_r, rx_nxt;
  logic [6:0] e_r, e_nxt, ope, ade, dme;
  logic [31:0] ad_r, ad_nxt;
  logic [15:0] left_r, left_nxt;
  logic [2:0] u_r, u_nxt;
  sfd_wsh_t w_r, w_nxt;
  logic qpi_r, qpi_nxt, cont_r, cont_nxt, a4_r, a4_nxt, cs_r, cs_nxt, sck_r, sck_nxt, push_r, push_nxt;
  logic [3:0] io_o_r, io_o_nxt, io_oe_r, io_oe_nxt, io_q1, io_q2;
  logic in_data, stall, f_ready;

  ////////////////////////////////////////////////////////////////////////////
  // pin capture and phase boundaries

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_q1 <= 4'hF;
      io_q2 <= 4'hF;
    end
    else
    begin
      io_q1 <= link.io;
      io_q2 <= io_q1;
    end
  end

  // enhance continuation has no opcode edges at all
  assign ope = cont_r ? 7'h00 : (qpi_r ? OPC_EDGES_QPI : OPC_EDGES_SPI);
  assign ade = ope + {1'b0, (a4_r ? ADDR4_BITS : ADDR3_BITS) >> w_r};
  assign dme = ade + {2'h0, sfd_dummy_clks(dummy_count_bit1, dummy_count_bit0), 1'b0};
  assign in_data = e_r >= dme;
  // clock stretches while the buffer is full, so no byte is lost
  assign stall = hc_r == HC_SMP && in_data && !f_ready;
  assign cmd_ready = st_r == H_IDLE && (cmd_width != W_QUAD || quad_enable_bit);
  assign busy = st_r != H_IDLE;
  assign link.cs_n = cs_r;
  assign link.sclk = sck_r;
  assign link.host_io_o = io_o_r;
  assign link.host_io_oe = io_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  always_comb
  begin
    st_nxt = st_r;
    hc_nxt = hc_r;
    e_nxt = e_r;
    op_nxt = op_r;
    ad_nxt = ad_r;
    ind_nxt = ind_r;
    rx_nxt = rx_r;
    left_nxt = left_r;
    u_nxt = u_r;
    w_nxt = w_r;
    qpi_nxt = qpi_r;
    cont_nxt = cont_r;
    a4_nxt = a4_r;
    cs_nxt = cs_r;
    sck_nxt = sck_r;
    io_o_nxt = io_o_r;
    io_oe_nxt = io_oe_r;
    push_nxt = 1'b0;
    unique case (st_r)
      H_IDLE:
      begin
        if (cmd_valid && cmd_ready)
        begin
          st_nxt = H_RUN;
          cs_nxt = 1'b0;
          hc_nxt = 8'h00;
          e_nxt = 7'h00;
          u_nxt = 3'h0;
          w_nxt = cmd_width;
          qpi_nxt = four_line_command_mode;
          cont_nxt = cmd_cont;
          a4_nxt = addr_4byte;
          left_nxt = cmd_len;
          ind_nxt = cmd_ind;
          ad_nxt = addr_4byte ? cmd_addr : {cmd_addr[23:0], 8'h00};
          op_nxt = (cmd_width == W_QUAD) ? OPC_QUAD : ((cmd_width == W_DUAL) ? OPC_DUAL : OPC_SINGLE);
        end
      end
      H_RUN:
      begin
        if (!stall)
          hc_nxt = (hc_r == HC_TOG) ? 8'h00 : hc_r + 8'h01;
        if (hc_r == HC_DRV && !in_data)
        begin
          io_oe_nxt = 4'h0;
          if (e_r < ope)
          begin
            // opcode goes out on rising edges only
            io_o_nxt = qpi_r ? op_r[7:4] : {3'h0, op_r[7]};
            io_oe_nxt = qpi_r ? 4'hF : 4'h1;
            if (!e_r[0])
              op_nxt = 8'(sfd_shl(qpi_r ? W_QUAD : W_SINGLE, {24'h0, op_r}));
          end
          else if (e_r < ade)
          begin
            io_o_nxt = sfd_lines(w_r, ad_r[31:24], 1'b1);
            io_oe_nxt = sfd_lines(w_r, 8'hFF, 1'b1);
            ad_nxt = sfd_shl(w_r, ad_r);
          end
          else if (w_r == W_QUAD && e_r < ade + 7'h02)
          begin
            io_o_nxt = ind_r[7:4];
            io_oe_nxt = 4'hF;
            ind_nxt = {ind_r[3:0], 4'h0};
          end
        end
        if (hc_r == HC_SMP && in_data && f_ready)
        begin
          rx_nxt = 8'(sfd_shin(w_r, {24'h0, rx_r}, io_q2, 1'b1));
          u_nxt = u_r + 3'h1;
          if (u_r == 3'h7 >> w_r)
          begin
            u_nxt = 3'h0;
            push_nxt = 1'b1;
            left_nxt = left_r - 16'h0001;
            if (left_r <= 16'h0001)
            begin
              st_nxt = H_END;
              hc_nxt = 8'h00;
            end
          end
        end
        if (hc_r == HC_TOG && !stall)
        begin
          sck_nxt = ~sck_r;
          if (!in_data)
            e_nxt = e_r + 7'h01;
        end
      end
      H_END:
      begin
        // deselect lands with the clock fall, so the clock never stands high while deselected
        cs_nxt = 1'b1;
        sck_nxt = 1'b0;
        io_oe_nxt = 4'h0;
        hc_nxt = hc_r + 8'h01;
        if (hc_r == HC_TOG)
          st_nxt = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= H_IDLE;
      hc_r <= 8'h00;
      e_r <= 7'h00;
      op_r <= 8'h00;
      ad_r <= 32'h0;
      ind_r <= 8'h00;
      rx_r <= 8'h00;
      left_r <= 16'h0000;
      u_r <= 3'h0;
      w_r <= W_SINGLE;
      qpi_r <= 1'b0;
      cont_r <= 1'b0;
      a4_r <= 1'b0;
      cs_r <= 1'b1;
      sck_r <= 1'b0;
      io_o_r <= 4'h0;
      io_oe_r <= 4'h0;
      push_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      hc_r <= hc_nxt;
      e_r <= e_nxt;
      op_r <= op_nxt;
      ad_r <= ad_nxt;
      ind_r <= ind_nxt;
      rx_r <= rx_nxt;
      left_r <= left_nxt;
      u_r <= u_nxt;
      w_r <= w_nxt;
      qpi_r <= qpi_nxt;
      cont_r <= cont_nxt;
      a4_r <= a4_nxt;
      cs_r <= cs_nxt;
      sck_r <= sck_nxt;
      io_o_r <= io_o_nxt;
      io_oe_r <= io_oe_nxt;
      push_r <= push_nxt;
    end
  end

  // received bytes wait here for the consumer
  sfd_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push_r),
    .in_ready(f_ready),
    .in_data(rx_r),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );
endmodule : sfd_host

// *** include/sfd_link_if.sv ***
// link between the host controller and the flash end
// assumes each end drives only its own enables; the wire is resolved here
`timescale 1ns/1ps
interface sfd_link_if;
  logic cs_n;
  logic sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // device wins a clash; an undriven line reads as pulled high
  assign io = (dev_io_oe & dev_io_o) | (host_io_oe & ~dev_io_oe & host_io_o) | ~(dev_io_oe | host_io_oe);

  modport dev (input cs_n, input sclk, input io, output dev_io_o, output dev_io_oe);
  modport host (output cs_n, output sclk, output host_io_o, output host_io_oe, input io);
endinterface : sfd_link_if

// *** include/sfd_pkg.sv ***
// shared constants, types and lane helpers for the dtr read path
// assumes both link ends and the testbench compile against this package
package sfd_pkg;

  typedef logic [1:0] sfd_wsh_t;
  // lane width as a shift: 1, 2 or 4 lines per edge
  localparam sfd_wsh_t W_SINGLE = 2'h0;
  localparam sfd_wsh_t W_DUAL = 2'h1;
  localparam sfd_wsh_t W_QUAD = 2'h2;

  localparam logic [7:0] OPC_SINGLE = 8'h0D;
  localparam logic [7:0] OPC_DUAL = 8'hBD;
  localparam logic [7:0] OPC_QUAD = 8'hED;

  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [2:0] OPC_RISES_SPI = 3'h7;
  localparam logic [2:0] OPC_RISES_QPI = 3'h1;
  localparam logic [6:0] OPC_EDGES_SPI = 7'h10;
  localparam logic [6:0] OPC_EDGES_QPI = 7'h04;

  // dummy clocks per dummy_count_bit1/bit0 setting
  localparam logic [3:0] DC_CLKS_00 = 4'h6;
  localparam logic [3:0] DC_CLKS_01 = 4'h4;
  localparam logic [3:0] DC_CLKS_10 = 4'h8;
  localparam logic [3:0] DC_CLKS_11 = 4'hA;

  localparam logic [7:0] PREAMBLE = 8'h34;
  localparam logic [4:0] IND_CLKS = 5'h02;
  localparam logic [3:0] IND_TOGGLE = 4'hF;
  localparam int HALF_DEFAULT = 8;
  localparam int FIFO_DEPTH = 4;

  function automatic logic [3:0] sfd_dummy_clks(input logic b1, input logic b0);
    unique case ({b1, b0})
      2'h0: sfd_dummy_clks = DC_CLKS_00;
      2'h1: sfd_dummy_clks = DC_CLKS_01;
      2'h2: sfd_dummy_clks = DC_CLKS_10;
      2'h3: sfd_dummy_clks = DC_CLKS_11;
    endcase
  endfunction : sfd_dummy_clks

  // top bits of b onto the lines; si picks io_line_0 for single width
  function automatic logic [3:0] sfd_lines(input sfd_wsh_t w, input logic [7:0] b, input logic si);
    case (w)
      W_SINGLE: sfd_lines = si ? {3'h0, b[7]} : {2'h0, b[7], 1'b0};
      W_DUAL: sfd_lines = {2'h0, b[7:6]};
      default: sfd_lines = b[7:4];
    endcase
  endfunction : sfd_lines

  function automatic logic [31:0] sfd_shl(input sfd_wsh_t w, input logic [31:0] x);
    case (w)
      W_SINGLE: sfd_shl = {x[30:0], 1'b0};
      W_DUAL: sfd_shl = {x[29:0], 2'h0};
      default: sfd_shl = {x[27:0], 4'h0};
    endcase
  endfunction : sfd_shl

  // shift line bits in at the bottom; so picks io_line_1 for single width
  function automatic logic [31:0] sfd_shin(input sfd_wsh_t w, input logic [31:0] x, input logic [3:0] io,
                                           input logic so);
    case (w)
      W_SINGLE: sfd_shin = {x[30:0], so ? io[1] : io[0]};
      W_DUAL: sfd_shin = {x[29:0], io[1:0]};
      default: sfd_shin = {x[27:0], io};
    endcase
  endfunction : sfd_shin

endpackage : sfd_pkg

// *** verif/sfd_link_assertions.sv ***
// link-level checker for the dtr read path
// assumes the host runs 8 clk per sclk half period
`timescale 1ns/1ps
module sfd_link_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_io_o,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_o,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // frame shape: clock parks low, halves last at least 8 clk
  idle_clk_low_a: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  sclk_half_a: assert property ($changed(sclk) |=> $stable(sclk) [*7])
    else $error("sclk half period too short");
  // both sides hold lines across each sampling edge
  line_hold_a: assert property (!cs_n && $changed(sclk) |-> $stable(host_io_o) && $stable(host_io_oe) && $stable(io))
    else $error("lines move on an sclk edge");
  dev_settle_a: assert property ($changed(dev_io_o) && (|dev_io_oe) |=> $stable(sclk) [*2])
    else $error("device data changes too close to an edge");
  // device drivers off for 8 clk after select and released within 6 clk of deselect
  dev_quiet_opc_a: assert property ($fell(cs_n) |-> (dev_io_oe == 4'h0) [*8])
    else $error("device drives during opcode");
  dev_off_a: assert property ($rose(cs_n) |-> ##[0:6] (dev_io_oe == 4'h0))
    else $error("device still drives after deselect");
  dev_late_a: assert property ((|dev_io_oe) |-> !$past(cs_n, 6))
    else $error("device drives while deselected");
  no_clash_idle_a: assert property (cs_n && $past(cs_n, 6) |-> (dev_io_oe & host_io_oe) == 4'h0)
    else $error("both ends drive while idle");
endmodule : sfd_link_assertions

// *** verif/tb.sv ***
// testbench: host and flash end joined by the link interface
// assumes a memory whose byte is its 8-bit address xor 5Ah
`timescale 1ns/1ps
module tb;
  import sfd_pkg::*;
  logic clk_sys, rst_n, cmd_valid, cmd_cont, rd_ready, rd_valid, cmd_ready, busy, enhance_active;
  logic quad_enable_bit, four_line_command_mode, addr_4byte, dummy_count_bit1, dummy_count_bit0;
  logic preamble_enable_bit, write_in_progress;
  sfd_wsh_t cmd_width;
  logic [31:0] cmd_addr;
  logic [15:0] cmd_len;
  logic [7:0] cmd_ind, rd_data, mem_data, mem_addr;
  int n_errors, n_tests;
  int cyc = 0;
  int n_rise, pre_n, pre_lim;
  logic sclk_d;
  logic [7:0] pre_r;
  sfd_link_if lk();
  ////////////////////////////////////////////////////////////////////////////
  // combinational memory pattern, small so the pointer wraps quickly
  assign mem_data = mem_addr ^ 8'h5A;
  sfd_host #(.HALF(8), .DEPTH(FIFO_DEPTH)) i_sfd_host (.clk_sys, .rst_n, .link(lk.host), .cmd_valid, .cmd_ready,
    .cmd_width, .cmd_addr, .cmd_len, .cmd_ind, .cmd_cont, .quad_enable_bit, .four_line_command_mode, .addr_4byte,
    .dummy_count_bit1, .dummy_count_bit0, .rd_valid, .rd_ready, .rd_data, .busy);
  sfd_dev #(.MEM_AW(8)) i_sfd_dev (.clk_sys, .rst_n, .link(lk.dev), .mem_addr, .mem_data, .write_in_progress,
    .dummy_count_bit1, .dummy_count_bit0, .preamble_enable_bit, .four_line_command_mode, .addr_4byte,
    .enhance_active);
  sfd_link_assertions i_sfd_link_assertions (.clk_sys, .rst_n, .cs_n(lk.cs_n), .sclk(lk.sclk),
    .host_io_o(lk.host_io_o), .host_io_oe(lk.host_io_oe), .dev_io_o(lk.dev_io_o), .dev_io_oe(lk.dev_io_oe),
    .io(lk.io));
  ////////////////////////////////////////////////////////////////////////////
  // 20 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // one read; ign expects pulled-up lines, stall holds the consumer off to fill the fifo
  task automatic rd(input sfd_wsh_t w, input logic [31:0] a, input int len, input logic [7:0] ind,
                    input logic cont, input logic ign, input int stall);
    int k;
    @(posedge clk_sys);
    {cmd_width, cmd_addr, cmd_len, cmd_ind, cmd_cont, cmd_valid, rd_ready} <= {w, a, 16'(len), ind, cont, 2'h2};
    k = 0;
    do @(negedge clk_sys); while (cmd_ready !== 1'b1 && ++k < 50);
    chk("cmd_ready", cmd_ready, 1);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (stall) @(posedge clk_sys);
    rd_ready <= 1'b1;
    for (int i = 0; i < len; i++)
    begin
      k = 0;
      do @(negedge clk_sys); while (rd_valid !== 1'b1 && ++k < 3000);
      chk("rd_valid", rd_valid, 1);
      chk("rd_data", rd_data, ign ? 8'hFF : 8'(a[7:0] + 8'(i)) ^ 8'h5A);
      @(posedge clk_sys);
    end
    k = 0;
    do @(negedge clk_sys); while (busy !== 1'b0 && ++k < 2000);
    chk("busy", busy, 0);
    @(posedge clk_sys);
    $display("test done: width %0d addr %0h", w, a);
  endtask : rd

  // preamble seen on io_line_0 at each link clock rise before the data phase
  always @(posedge clk_sys)
  begin
    sclk_d <= lk.sclk;
    if (lk.cs_n)
      n_rise <= 0;
    else if (lk.sclk && !sclk_d)
    begin
      n_rise <= n_rise + 1;
      if (n_rise == 0)
      begin
        pre_n <= 0;
        pre_r <= 8'h00;
      end
      else if (lk.dev_io_oe != 4'h0 && n_rise < pre_lim)
      begin
        pre_r <= {pre_r[6:0], lk.io[0]};
        pre_n <= pre_n + 1;
      end
    end
  end

  // hang guard, well above the expected run length
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_errors++;
      test_done();
    end
  end

  // main sequence
  initial
  begin
    {rst_n, cmd_valid, cmd_cont, rd_ready, quad_enable_bit, four_line_command_mode, addr_4byte} = '0;
    {dummy_count_bit1, dummy_count_bit0, preamble_enable_bit, write_in_progress} = '0;
    {cmd_width, cmd_addr, cmd_len, cmd_ind} = '0;
    n_errors = 0;
    n_tests = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(W_SINGLE, 32'h0000_00FE, 4, 8'h00, 1'b0, 1'b0, 0);
    for (int d = 0; d < 4; d++)
    begin
      {dummy_count_bit1, dummy_count_bit0} <= 2'(d);
      rd(W_DUAL, 32'(d * 16), 3, 8'h00, 1'b0, 1'b0, 0);
    end
    preamble_enable_bit <= 1'b1;
    quad_enable_bit <= 1'b1;
    // rises before data: opcode 8, address 3, dummy 10
    pre_lim <= 8 + 3 + 10;
    rd(W_QUAD, 32'h40, 2, 8'hA5, 1'b0, 1'b0, 0);
    chk("enhance_active", enhance_active, 1);
    chk("preamble_bits", pre_n, 8);
    chk("preamble", pre_r, PREAMBLE);
    rd(W_QUAD, 32'h80, 2, 8'h0F, 1'b1, 1'b0, 0);
    chk("enhance_active", enhance_active, 1);
    {dummy_count_bit1, dummy_count_bit0} <= 2'h2;
    // no opcode now: address 3, dummy 8
    pre_lim <= 3 + 8;
    rd(W_QUAD, 32'hC0, 2, 8'hFF, 1'b1, 1'b0, 0);
    chk("enhance_active", enhance_active, 0);
    chk("preamble_bits", pre_n, 6);
    chk("preamble", pre_r, {2'h0, PREAMBLE[7:2]});
    preamble_enable_bit <= 1'b0;
    four_line_command_mode <= 1'b1;
    rd(W_QUAD, 32'h20, 8, 8'h00, 1'b0, 1'b0, 400);
    four_line_command_mode <= 1'b0;
    addr_4byte <= 1'b1;
    rd(W_SINGLE, 32'h0100_0133, 2, 8'h00, 1'b0, 1'b0, 0);
    addr_4byte <= 1'b0;
    write_in_progress <= 1'b1;
    rd(W_DUAL, 32'h05, 2, 8'h00, 1'b0, 1'b1, 0);
    write_in_progress <= 1'b0;
    quad_enable_bit <= 1'b0;
    cmd_width <= W_QUAD;
    cmd_valid <= 1'b1;
    repeat (20) @(negedge clk_sys);
    chk("cmd_ready", cmd_ready, 0);
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    $display("test done: quad refused without enable");
    test_done();
  end
endmodule : tb
